// >>> shared/scss_regs.vh
// register map, field positions and timing constants for clock source select
`ifndef SCSS_REGS_VH
`define SCSS_REGS_VH

// register byte offsets
`define SCSS_OSC_CTRL_ADDR    8'h00
`define SCSS_STATUS_ADDR      8'h04
`define SCSS_TIMER_CTRL_ADDR  8'h08
`define SCSS_FIRST_PORT_ADDR       8'h0c

// oscillator_control fields
`define SCSS_SWITCH_BIT       0
`define SCSS_OSC_CTRL_RESET   8'h00

// status fields
`define SCSS_ST_SRC_BIT       0
`define SCSS_ST_BUSY_BIT      1
`define SCSS_ST_RUN_BIT       2
`define SCSS_ST_PLL_BIT       3
`define SCSS_ST_MODE_LSB      4

// timer_one_control fields
`define SCSS_SEC_EN_BIT       0

// primary oscillator modes
`define SCSS_MODE_LP          3'h0
`define SCSS_MODE_XT          3'h1
`define SCSS_MODE_HS          3'h2
`define SCSS_MODE_RC          3'h3
`define SCSS_MODE_EC          3'h4
`define SCSS_MODE_EXT_CLOCK_IO_MODE        3'h5
`define SCSS_MODE_HS4         3'h6
`define SCSS_MODE_RC_IO_MODE        3'h7

// timing
`define SCSS_SYNC_EDGES       8
`define SCSS_OST_CYCLES       1024
`define SCSS_PLL_LOCK_US      2000
`define SCSS_CLK_MHZ          20
`define SCSS_PLL_LOCK_CYC     (`SCSS_PLL_LOCK_US * `SCSS_CLK_MHZ)

`endif

// >>> verilog/scss_top.v
// clock source selection with glitch-free switching and axi4-lite registers
// Summary of operation
// - rc clock-out mode drives secondary pin with primary clock divided by 4.
// - external clock-out mode drives secondary pin with input clock divided by 4.
// - rc io mode releases secondary pin as port a bit six.
// - external clock io mode releases secondary pin as general purpose io.
// - both external clock modes switch off the oscillator feedback element.
// - external clock modes need no start-up delay after reset or sleep.
// - pll option multiplies the crystal frequency by 4.
// - pll only in high-speed pll mode; otherwise clock comes straight from input.
// - execution held until the pll lock timer expires.
// - switching allowed only when enable configuration bit is 0.
// - switch bit 0 selects primary oscillator, 1 selects secondary oscillator.
// - clock switch bit cleared by every reset.
// - without secondary oscillator enabled, switch writes ignored, bit stays 0.
// - any source change waits eight rising edges of the target clock.
// - to secondary: freeze at first quarter phase, count eight, resume.
// - back to crystal mode waits the oscillator start-up delay.
// - back to pll mode waits start-up delay then pll lock time.
// - back to rc or external modes skips start-up, waits eight cycles.
// - oscillator control reads zero on bits 7..1, switch bit at 0.
// - eight primary modes chosen by a three-bit configuration field.
// - start-up delay counts 1024 primary oscillator input cycles.
//
// Decided for this implementation: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
`include "scss_regs.vh"

module scss_top #(
  parameter integer PLL_LOCK_CYC = `SCSS_PLL_LOCK_CYC,
  parameter integer OST_CYC      = `SCSS_OST_CYCLES,
  parameter integer SYNC_EDGES   = `SCSS_SYNC_EDGES
) (
  // clock and reset
  input  wire        aclk,
  input  wire        aresetn,
  // axi4-lite write address
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  // axi4-lite write data
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  // axi4-lite write response
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  // axi4-lite read address
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  // axi4-lite read data
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  // static configuration
  input  wire [2:0]  osc_mode_cfg,
  input  wire        switching_enable_cfg_n,
  // clock sources, sampled as levels
  input  wire        primary_osc_in,
  input  wire        secondary_osc_in,
  input  wire        pll_clk_in,
  // secondary oscillator pin
  input  wire        secondary_osc_pin_i,
  output reg         secondary_osc_pin_o,
  output reg         secondary_osc_pin_oe,
  // oscillator analog controls
  output reg         osc_feedback_en,
  output reg         pll_enable,
  // system clock and core hold
  output reg         sys_clk_out,
  output reg         cpu_run,
  input  wire        first_quarter_phase
);

  // ********************************************************************
  // state and local signals
  // ********************************************************************
  localparam [2:0] ST_RUN  = 3'h0;
  localparam [2:0] ST_FRZ  = 3'h1;
  localparam [2:0] ST_OST  = 3'h2;
  localparam [2:0] ST_PLL  = 3'h3;
  localparam [2:0] ST_SYNC = 3'h4;

  reg  [2:0]  st_q;
  reg  [2:0]  mode_q;
  reg         sw_dis_q;
  reg         cfg_done_q;
  reg         switch_q;
  reg         sec_en_q;
  reg         src_q;
  reg         tgt_q;
  reg  [31:0] cnt_q;
  reg  [1:0]  div_q;
  reg         port_bit_q;
  reg         prim_d1_q;
  reg         sec_d1_q;
  reg         aw_got_q;
  reg         w_got_q;
  reg  [7:0]  aw_addr_q;
  reg  [31:0] w_data_q;
  reg  [3:0]  w_strb_q;

  wire prim_rise = primary_osc_in & ~prim_d1_q;
  wire sec_rise  = secondary_osc_in & ~sec_d1_q;
  wire tgt_rise  = tgt_q ? sec_rise : prim_rise;
  wire is_xtal   = (mode_q == `SCSS_MODE_LP) | (mode_q == `SCSS_MODE_XT) |
                   (mode_q == `SCSS_MODE_HS) | (mode_q == `SCSS_MODE_HS4);
  wire is_pll    = (mode_q == `SCSS_MODE_HS4);
  wire is_ext    = (mode_q == `SCSS_MODE_EC) | (mode_q == `SCSS_MODE_EXT_CLOCK_IO_MODE);
  wire is_io     = (mode_q == `SCSS_MODE_RC_IO_MODE) | (mode_q == `SCSS_MODE_EXT_CLOCK_IO_MODE);
  wire sel_eff   = switch_q & sec_en_q & ~sw_dis_q;

  // ********************************************************************
  // static configuration capture
  // ********************************************************************
  always @(posedge aclk)
  begin
    if (!aresetn)
      cfg_done_q <= 1'b0;
    else
      cfg_done_q <= 1'b1;
  end

  always @(posedge aclk)
  begin
    if (!cfg_done_q)
    begin
      mode_q   <= osc_mode_cfg;
      sw_dis_q <= switching_enable_cfg_n;
    end
  end

  // ********************************************************************
  // axi4-lite slave
  // ********************************************************************
  wire wr_go = aw_got_q & w_got_q & ~s_axi_bvalid;
  assign s_axi_awready = ~aw_got_q & ~s_axi_bvalid;
  assign s_axi_wready  = ~w_got_q & ~s_axi_bvalid;
  assign s_axi_arready = ~s_axi_rvalid;

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_got_q     <= 1'b0;
      w_got_q      <= 1'b0;
      aw_addr_q    <= 8'h00;
      w_data_q     <= 32'h0000_0000;
      w_strb_q     <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= 2'h0;
      switch_q     <= 1'b0;
      sec_en_q     <= 1'b0;
      port_bit_q   <= 1'b0;
    end
    else
    begin
      if (s_axi_awvalid & s_axi_awready)
      begin
        aw_got_q  <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid & s_axi_wready)
      begin
        w_got_q  <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
      if (wr_go)
      begin
        aw_got_q     <= 1'b0;
        w_got_q      <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= 2'h0;
        case (aw_addr_q)
          `SCSS_OSC_CTRL_ADDR:
            if (w_strb_q[0])
              switch_q <= w_data_q[`SCSS_SWITCH_BIT]
                          & sec_en_q & ~sw_dis_q;
          `SCSS_TIMER_CTRL_ADDR:
            if (w_strb_q[0])
              sec_en_q <= w_data_q[`SCSS_SEC_EN_BIT];
          `SCSS_FIRST_PORT_ADDR:
            if (w_strb_q[0])
              port_bit_q <= w_data_q[6];
          `SCSS_STATUS_ADDR: ;
          default:
            s_axi_bresp <= 2'h2;
        endcase
      end
      else if (s_axi_bvalid & s_axi_bready)
        s_axi_bvalid <= 1'b0;
      // secondary oscillator turned off forces primary
      if (!sec_en_q)
        switch_q <= 1'b0;
    end
  end

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= 2'h0;
    end
    else if (s_axi_arvalid & s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= 2'h0;
      case (s_axi_araddr)
        `SCSS_OSC_CTRL_ADDR:
          s_axi_rdata <= {31'h0, switch_q};
        `SCSS_STATUS_ADDR:
          s_axi_rdata <= {25'h0, mode_q, pll_enable, cpu_run,
                          (st_q != ST_RUN), src_q};
        `SCSS_TIMER_CTRL_ADDR:
          s_axi_rdata <= {31'h0, sec_en_q};
        `SCSS_FIRST_PORT_ADDR:
          s_axi_rdata <= {25'h0, secondary_osc_pin_i, 6'h00};
        default:
        begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= 2'h2;
        end
      endcase
    end
    else if (s_axi_rvalid & s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

  // ********************************************************************
  // switch sequencer
  // ********************************************************************
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      prim_d1_q <= 1'b0;
      sec_d1_q  <= 1'b0;
    end
    else
    begin
      prim_d1_q <= primary_osc_in;
      sec_d1_q  <= secondary_osc_in;
    end
  end

  always @(posedge aclk)
  begin
    if (!aresetn || !cfg_done_q)
    begin
      st_q    <= ST_PLL;
      src_q   <= 1'b0;
      tgt_q   <= 1'b0;
      cnt_q   <= 32'h0;
      cpu_run <= 1'b0;
    end
    else
    begin
      case (st_q)
        ST_RUN:
          if (sel_eff != src_q)
          begin
            tgt_q <= sel_eff;
            cnt_q <= 32'h0;
            if (sel_eff)
              st_q <= ST_FRZ;
            else
            begin
              cpu_run <= 1'b0;
              st_q    <= is_xtal ? ST_OST : ST_SYNC;
            end
          end
        ST_FRZ:
          if (first_quarter_phase)
          begin
            cpu_run <= 1'b0;
            st_q    <= ST_SYNC;
          end
        ST_OST:
          if (prim_rise)
          begin
            if (cnt_q == OST_CYC - 1)
            begin
              cnt_q <= 32'h0;
              st_q  <= is_pll ? ST_PLL : ST_SYNC;
            end
            else
              cnt_q <= cnt_q + 32'h1;
          end
        ST_PLL:
          // held from reset until lock timer expires
          if (!is_pll || cnt_q == PLL_LOCK_CYC - 1)
          begin
            cnt_q <= 32'h0;
            if (src_q != tgt_q)
              st_q <= ST_SYNC;
            else
            begin
              cpu_run <= 1'b1;
              st_q    <= ST_RUN;
            end
          end
          else
            cnt_q <= cnt_q + 32'h1;
        ST_SYNC:
          if (tgt_rise)
          begin
            if (cnt_q == SYNC_EDGES - 1)
            begin
              cnt_q   <= 32'h0;
              src_q   <= tgt_q;
              cpu_run <= 1'b1;
              st_q    <= ST_RUN;
            end
            else
              cnt_q <= cnt_q + 32'h1;
          end
        default:
          st_q <= ST_RUN;
      endcase
    end
  end

  // ********************************************************************
  // clock mux and pin control
  // ********************************************************************
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      sys_clk_out          <= 1'b0;
      div_q                <= 2'h0;
      secondary_osc_pin_o  <= 1'b0;
      secondary_osc_pin_oe <= 1'b0;
      osc_feedback_en      <= 1'b0;
      pll_enable           <= 1'b0;
    end
    else
    begin
      if (st_q == ST_RUN || st_q == ST_FRZ)
        sys_clk_out <= src_q ? secondary_osc_in :
                       (is_pll ? pll_clk_in : primary_osc_in);
      else
        sys_clk_out <= 1'b0;
      if (prim_rise)
        div_q <= div_q + 2'h1;
      pll_enable      <= is_pll;
      osc_feedback_en <= ~is_ext;
      if (is_io)
      begin
        secondary_osc_pin_o  <= port_bit_q;
        secondary_osc_pin_oe <= 1'b1;
      end
      else if (mode_q == `SCSS_MODE_RC || mode_q == `SCSS_MODE_EC)
      begin
        secondary_osc_pin_o  <= div_q[1];
        secondary_osc_pin_oe <= 1'b1;
      end
      else
      begin
        secondary_osc_pin_o  <= 1'b0;
        secondary_osc_pin_oe <= 1'b0;
      end
    end
  end

endmodule // scss_top

// >>> bench/scss_partner.sv
// partner model: free-running external oscillator sources
`timescale 1ns/1ps
module scss_partner (
  // oscillator outputs
  output reg primary_osc_in   = 1'b0,
  output reg secondary_osc_in = 1'b0,
  output reg pll_clk_in       = 1'b0
);
  // 200 ns, 620 ns, 60 ns periods; no toggle lands on a rising aclk edge
  always #100 primary_osc_in = ~primary_osc_in;
  always #310 secondary_osc_in = ~secondary_osc_in;
  always #30 pll_clk_in = ~pll_clk_in;
endmodule // scss_partner

// >>> bench/scss_top_asserts.sv
// checker: mode outputs, lock wait and control register read data
`timescale 1ns/1ps
module scss_chk #(
  parameter integer PLL_LOCK_CYC = 40000
) (
  // clock and reset
  input wire        aclk,
  input wire        aresetn,
  // read channel
  input wire [7:0]  s_axi_araddr,
  input wire        s_axi_arvalid,
  input wire        s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire        s_axi_rvalid,
  // mode and clock outputs
  input wire [2:0]  osc_mode_cfg,
  input wire        pll_enable,
  input wire        osc_feedback_en,
  input wire        secondary_osc_pin_oe,
  input wire        sys_clk_out,
  input wire        cpu_run
);
  reg [7:0]  ar_q;
  reg [15:0] lc_q;
  reg        seen_q;
  // cycles since release until the core first runs
  always @(posedge aclk)
  begin
    if (s_axi_arvalid && s_axi_arready)
      ar_q <= s_axi_araddr;
    if (!aresetn)
      lc_q <= 16'h0000;
    else if (!seen_q)
      lc_q <= lc_q + 16'h0001;
    seen_q <= aresetn && (seen_q || cpu_run);
  end
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  chk_pll_only: assert property (pll_enable |-> osc_mode_cfg == 3'h6)
    else $error("pll enabled outside pll mode");
  chk_pll_mode: assert property (seen_q && osc_mode_cfg == 3'h6 |-> pll_enable)
    else $error("pll off in pll mode");
  chk_fb_off: assert property (seen_q && osc_mode_cfg[2:1] == 2'h2
    |-> !osc_feedback_en) else $error("feedback on in external clock mode");
  chk_div_pin: assert property (seen_q && (osc_mode_cfg == 3'h3
    || osc_mode_cfg == 3'h4) |-> secondary_osc_pin_oe)
    else $error("clock out pin not driven");
  chk_mux_hold: assert property (!cpu_run && !$past(cpu_run)
    |-> !sys_clk_out) else $error("clock pulses while core held");
  chk_lock_wait: assert property ($rose(cpu_run) && !seen_q
    && osc_mode_cfg == 3'h6 |-> lc_q >= PLL_LOCK_CYC - 1)
    else $error("core ran before pll lock time");
  chk_lock_done: assert property ($rose(aresetn) && osc_mode_cfg == 3'h6
    |-> ##[1:60] cpu_run) else $error("core never ran after lock");
  chk_no_ost: assert property ($rose(aresetn) && osc_mode_cfg[2:1] == 2'h2
    |-> ##[1:4] cpu_run) else $error("start-up delay in external clock mode");
  chk_rd_ctrl: assert property (s_axi_rvalid && ar_q == 8'h00
    |-> s_axi_rdata[31:1] == 31'h0) else $error("control upper bits not zero");
endmodule // scss_chk
bind scss_top scss_chk #(.PLL_LOCK_CYC(PLL_LOCK_CYC)) chk_u (.aclk, .aresetn,
  .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid,
  .osc_mode_cfg, .pll_enable, .osc_feedback_en, .secondary_osc_pin_oe,
  .sys_clk_out, .cpu_run);

// >>> bench/tb.sv
// testbench: register access, mode sweep and clock switch timing
`timescale 1ns/1ps
module tb;
  reg         aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0;
  reg         s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0, p;
  reg  [7:0]  s_axi_awaddr = 0, s_axi_araddr = 0;
  reg  [31:0] s_axi_wdata = 0, rd;
  reg  [3:0]  s_axi_wstrb = 4'h1;
  reg  [2:0]  osc_mode_cfg = 0, md;
  reg         switching_enable_cfg_n = 0, first_quarter_phase = 1;
  reg  [1:0]  rr;
  wire        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  wire        s_axi_rvalid, secondary_osc_pin_o, secondary_osc_pin_oe;
  wire        osc_feedback_en, pll_enable, sys_clk_out, cpu_run;
  wire        primary_osc_in, secondary_osc_in, pll_clk_in;
  wire [1:0]  s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  integer     mismatches = 0, checks_done = 0, cyc = 0, n, m, e;
  // undriven pin shows the inverse of secondary_osc_pin_o, which is 0 while released, so it reads 1
  wire secondary_osc_pin_i = secondary_osc_pin_oe ? secondary_osc_pin_o
                                                  : ~secondary_osc_pin_o;
  scss_partner osc_u (.primary_osc_in, .secondary_osc_in, .pll_clk_in);
  scss_top #(.PLL_LOCK_CYC(20), .OST_CYC(16)) dut_u (.aclk, .aresetn,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .osc_mode_cfg, .switching_enable_cfg_n,
    .primary_osc_in, .secondary_osc_in, .pll_clk_in, .secondary_osc_pin_i,
    .secondary_osc_pin_o, .secondary_osc_pin_oe, .osc_feedback_en,
    .pll_enable, .sys_clk_out, .cpu_run, .first_quarter_phase);
  always #25 aclk = ~aclk;
  always @(posedge aclk)
  begin
    cyc = cyc + 1;
    if (cyc == 20000)
    begin
      mismatches = mismatches + 1;
      finish_test;
    end
  end
  task finish_test;
    begin
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0)
        $display("Simulation passed");
      else
        $display("Simulation failed");
      $finish;
    end
  endtask
  task cmp(input [127:0] nm, input [31:0] ex, input [31:0] got);
    begin
      checks_done = checks_done + 1;
      if (got !== ex)
      begin
        mismatches = mismatches + 1;
        $display("BAD %0s exp %h got %h", nm, ex, got);
      end
    end
  endtask
  task rst(input [2:0] mode, input cn);
    begin
      @(posedge aclk);
      aresetn <= 0;
      osc_mode_cfg <= mode;
      switching_enable_cfg_n <= cn;
      repeat (16) @(posedge aclk);
      aresetn <= 1;
      repeat (2) @(posedge aclk);
    end
  endtask
  // readiness sampled mid-cycle, equal to its value at the next rising edge
  task wr(input [7:0] a, input [31:0] d);
    reg pa, pw, t;
    begin
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
      {pa, pw, t} = 3'h6;
      while (!t)
      begin
        @(negedge aclk);
        pa = pa && !s_axi_awready;
        pw = pw && !s_axi_wready;
        t = s_axi_bvalid;
        rr = s_axi_bresp;
        @(posedge aclk);
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {pa, pw, !t};
      end
    end
  endtask
  task rdr(input [7:0] a);
    reg pa, t;
    begin
      @(posedge aclk);
      s_axi_araddr <= a;
      {s_axi_arvalid, s_axi_rready} <= 2'h3;
      {pa, t} = 2'h2;
      while (!t)
      begin
        @(negedge aclk);
        pa = pa && !s_axi_arready;
        t = s_axi_rvalid;
        {rd, rr} = {s_axi_rdata, s_axi_rresp};
        @(posedge aclk);
        {s_axi_arvalid, s_axi_rready} <= {pa, !t};
      end
    end
  endtask
  task wrun(input v);
    begin
      n = 0;
      while (cpu_run !== v && n < 3000)
      begin
        @(negedge aclk);
        n = n + 1;
      end
    end
  endtask
  initial
  begin
    for (m = 0; m < 8; m = m + 1)
    begin
      rst(m[2:0], 0);
      rdr(8'h04);
      cmp("mode", m, rd[6:4]);
      rdr(8'h00);
      cmp("ctrl", 0, rd);
      @(negedge aclk);
      cmp("pll", m == 6, pll_enable);
      cmp("fb", !(m == 4 || m == 5), osc_feedback_en);
      if (m == 3 || m == 4)
      begin
        n = 0;
        p = secondary_osc_pin_o;
        repeat (128)
        begin
          @(negedge aclk);
          n = n + (secondary_osc_pin_o && !p);
          p = secondary_osc_pin_o;
        end
        cmp("div4", 8, n);
      end
      if (m == 5 || m == 7)
      begin
        wr(8'h0c, 32'h40);
        @(negedge aclk);
        cmp("io1", 2'h3, {secondary_osc_pin_oe, secondary_osc_pin_o});
        rdr(8'h0c);
        cmp("pin_in", 32'h40, rd);
        wr(8'h0c, 32'h0);
        @(negedge aclk);
        cmp("io0", 0, secondary_osc_pin_o);
      end
    end
    rdr(8'h10);
    cmp("unmapped", 2, rr);
    wr(8'h10, 0);
    cmp("wr_unmapped", 2, rr);
    for (m = 0; m < 3; m = m + 1)
    begin
      md = (m == 0) ? 3'h2 : (m == 1) ? 3'h6 : 3'h3;
      rst(md, 0);
      wrun(1);
      wr(8'h00, 1);
      rdr(8'h00);
      cmp("ignored", 0, rd);
      wr(8'h08, 1);
      first_quarter_phase <= 0;
      wr(8'h00, 1);
      repeat (10) @(negedge aclk);
      cmp("frozen", 1, cpu_run);
      @(posedge aclk);
      first_quarter_phase <= 1;
      wrun(0);
      wrun(1);
      cmp("to_sec", 1, n >= 86 && n <= 115);
      rdr(8'h04);
      cmp("src", 1, rd[0]);
      wr(8'h00, 0);
      wrun(0);
      wrun(1);
      e = 32 + (md == 3'h3 ? 0 : 64) + (md == 3'h6 ? 20 : 0);
      cmp("back", 1, n >= e - 6 && n <= e + 12);
      wr(8'h00, 1);
    end
    rst(3'h2, 1);
    switching_enable_cfg_n <= 0;
    osc_mode_cfg <= 3'h1;
    wr(8'h08, 1);
    wr(8'h00, 1);
    rdr(8'h00);
    cmp("disabled", 0, rd);
    rdr(8'h04);
    cmp("cfg_held", 2, rd[6:4]);
    finish_test;
  end
endmodule // tb
